// ### hdl/epc_top.v
// Quadrature encoder position counter with APB register slave.
// Assumes pins mf_in are asynchronous; exp_start/exp_len come from
// exposure control on pclk.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "epc_defs.vh"

module epc_top #(
   parameter EXP_W = 24
) (
   input  wire              pclk,
   input  wire              presetn,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [7:0]        paddr,
   input  wire [31:0]       pwdata,
   output wire              pready,
   output wire              pslverr,
   output wire [31:0]       prdata,
   input  wire [2:0]        mf_in,
   input  wire              exp_start,
   input  wire [EXP_W-1:0]  exp_len,
   output wire [31:0]       pos_count,
   output wire [31:0]       meas_pos,
   output wire              meas_valid,
   output wire              pos_hit,
   output wire              trig_out
);

   reg  [`EPC_CTRL_W-1:0]  ctrl_r;
   reg  [`EPC_MAP_W-1:0]   map_r;
   reg  [31:0]             maxv_r;
   reg  [31:0]             preset_r;
   reg  [31:0]             cmp_r;
   reg  [31:0]             cnt_r;
   reg  [31:0]             cnt_nxt;
   reg                     seen_r;
   reg                     dir_r;
   reg  [31:0]             prdata_r;
   reg                     perr_r;
   reg  [2:0]              sync1_r;
   reg  [2:0]              sync2_r;
   reg                     a_q_r;
   reg                     b_q_r;
   reg                     ref_q_r;
   reg                     trig_r;
   reg                     hit_r;
   reg                     exp_busy_r;
   reg  [EXP_W-1:0]        exp_cnt_r;
   reg  [EXP_W-1:0]        exp_len_r;
   reg  [31:0]             mid_r;
   reg  [31:0]             meas_r;
   reg                     mvalid_r;

   wire                    wr_acc;
   wire                    setup;
   wire                    load_cmd;
   wire                    rearm_cmd;

   // Zero wait states: read data and error are settled in the setup cycle
   // A refused write is blocked in its access cycle by the latched error
   assign pready  = 1'b1;
   assign setup   = psel & ~penable;
   assign wr_acc  = psel & penable & pwrite & ~perr_r;
   assign pslverr = perr_r & psel & penable;
   assign prdata  = prdata_r;

   assign load_cmd  = wr_acc & (paddr == `EPC_ADDR_CMD) &
                      pwdata[`EPC_CMD_LOAD];
   assign rearm_cmd = wr_acc & (paddr == `EPC_ADDR_CMD) &
                      pwdata[`EPC_CMD_REARM];

   // Mapping check on the word being written
   wire [1:0] f0 = pwdata[`EPC_MAP_IN0];
   wire [1:0] f1 = pwdata[`EPC_MAP_IN1];
   wire [1:0] f2 = pwdata[`EPC_MAP_IN2];
   wire       has_ref  = (f0 == `EPC_FN_REF) | (f1 == `EPC_FN_REF) |
                         (f2 == `EPC_FN_REF);
   wire       has_trig = (f0 == `EPC_FN_TRIG) | (f1 == `EPC_FN_TRIG) |
                         (f2 == `EPC_FN_TRIG);
   wire       map_ok   = (f0 != f1) & (f0 != f2) & (f1 != f2) &
                         ~(has_ref & has_trig);
   wire       ctrl_ok  = (pwdata[`EPC_CTRL_INTERP] != `EPC_MODE_BAD) &
                         (pwdata[`EPC_CTRL_REFMODE] != `EPC_MODE_BAD);

   reg        err_nxt;
   reg [31:0] rd_nxt;

   always @* begin
      err_nxt = 1'b0;
      rd_nxt  = `EPC_ZERO32;
      case (paddr)
         `EPC_ADDR_CTRL: begin
            rd_nxt  = {28'h0000000, ctrl_r};
            err_nxt = pwrite & ~ctrl_ok;
         end
         `EPC_ADDR_MAP: begin
            rd_nxt  = {26'h0, map_r};
            err_nxt = pwrite & ~map_ok;
         end
         `EPC_ADDR_MAXV: begin
            rd_nxt  = maxv_r;
            err_nxt = pwrite & (pwdata == `EPC_ZERO32);
         end
         `EPC_ADDR_PRESET: rd_nxt = preset_r;
         `EPC_ADDR_CMD:    rd_nxt = `EPC_ZERO32;
         `EPC_ADDR_COUNT: begin
            rd_nxt  = cnt_r;
            err_nxt = pwrite;
         end
         `EPC_ADDR_STATUS: begin
            rd_nxt  = {30'h0, dir_r, seen_r};
            err_nxt = pwrite;
         end
         `EPC_ADDR_CAPT: begin
            rd_nxt  = meas_r;
            err_nxt = pwrite;
         end
         `EPC_ADDR_CMP:    rd_nxt = cmp_r;
         default:          err_nxt = 1'b1;
      endcase
   end

   // Latched at setup so read data stands through the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= `EPC_ZERO32;
         perr_r   <= 1'b0;
      end else if (setup) begin
         prdata_r <= rd_nxt;
         perr_r   <= err_nxt;
      end
   end

   // Configuration registers; rejected writes leave them untouched
   // Command, count and status addresses fall to default: nothing stored
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r   <= `EPC_CTRL_RST;
         map_r    <= `EPC_MAP_RST;
         maxv_r   <= `EPC_MAXV_RST;
         preset_r <= `EPC_PRESET_RST;
         cmp_r    <= `EPC_CMP_RST;
      end else if (wr_acc) begin
         case (paddr)
            `EPC_ADDR_CTRL:   ctrl_r   <= pwdata[`EPC_CTRL_W-1:0];
            `EPC_ADDR_MAP:    map_r    <= pwdata[`EPC_MAP_W-1:0];
            `EPC_ADDR_MAXV:   maxv_r   <= pwdata;
            `EPC_ADDR_PRESET: preset_r <= pwdata;
            `EPC_ADDR_CMP:    cmp_r    <= pwdata;
            default:          ;
         endcase
      end
   end

   // Pin synchronisers, one pair of flip-flops per input
   // Only the second stage feeds logic, keeping metastability out
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1_r[gi] <= 1'b0;
               sync2_r[gi] <= 1'b0;
            end else begin
               sync1_r[gi] <= mf_in[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   // Level of the input carrying a function, low when unmapped
   // Low matches the idle level of the pins after reset
   function pick;
      input [1:0]           fn;
      input [`EPC_MAP_W-1:0] m;
      input [2:0]           s;
      begin
         pick = ((m[`EPC_MAP_IN0] == fn) & s[0]) |
                ((m[`EPC_MAP_IN1] == fn) & s[1]) |
                ((m[`EPC_MAP_IN2] == fn) & s[2]);
      end
   endfunction

   wire trk_a   = pick(`EPC_FN_A, map_r, sync2_r);
   wire trk_b   = pick(`EPC_FN_B, map_r, sync2_r);
   wire trk_ref = pick(`EPC_FN_REF, map_r, sync2_r);
   wire trk_tg  = pick(`EPC_FN_TRIG, map_r, sync2_r);

   // Last levels reset low, the idle level of every pin
   // The trigger level takes the same delay as the edge path
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_q_r   <= 1'b0;
         b_q_r   <= 1'b0;
         ref_q_r <= 1'b0;
         trig_r  <= 1'b0;
      end else begin
         a_q_r   <= trk_a;
         b_q_r   <= trk_b;
         ref_q_r <= trk_ref;
         trig_r  <= trk_tg;
      end
   end

   wire edge_a  = trk_a ^ a_q_r;
   wire edge_b  = trk_b ^ b_q_r;
   wire ref_ev  = trk_ref & ~ref_q_r;
   // A step forward when A leads B
   wire up_a    = trk_a ^ trk_b;
   wire up_b    = ~(trk_a ^ trk_b);

   reg  step;
   reg  up;

   always @* begin
      step = 1'b0;
      up   = 1'b0;
      case (ctrl_r[`EPC_CTRL_INTERP])
         `EPC_INT_X1: begin
            step = edge_a & trk_a;
            up   = ~trk_b;
         end
         `EPC_INT_X2: begin
            step = edge_a;
            up   = up_a;
         end
         `EPC_INT_X4: begin
            // Both tracks moving at once is a lost step; ignore it
            step = edge_a ^ edge_b;
            up   = edge_a ? up_a : up_b;
         end
         default: begin
            step = 1'b0;
            up   = 1'b0;
         end
      endcase
   end

   wire [1:0] refmode = ctrl_r[`EPC_CTRL_REFMODE];
   // Mode none lets marks pass; only reset and command load then
   wire ref_off  = (refmode == `EPC_REF_NONE);
   wire ref_load = ref_ev & ~ref_off &
                   ((refmode == `EPC_REF_ALL) |
                    ((refmode == `EPC_REF_ONCE) & ~seen_r));

   // The upward wrap test uses >= so a maximum lowered below the count still wraps; the downward test uses ==
   wire [31:0] cnt_inc = cnt_r + `EPC_ONE32;
   wire [31:0] cnt_dec = cnt_r - `EPC_ONE32;
   wire        at_max  = (cnt_r >= maxv_r);
   wire        at_zero = (cnt_r == `EPC_ZERO32);

   // Command load beats a mark, a mark beats a count step
   always @* begin
      cnt_nxt = cnt_r;
      if (load_cmd)
         cnt_nxt = preset_r;
      else if (ref_load)
         cnt_nxt = preset_r;
      else if (step & up)
         cnt_nxt = at_max ? `EPC_ZERO32 : cnt_inc;
      else if (step)
         cnt_nxt = at_zero ? maxv_r : cnt_dec;
   end

   // Reset value equals the preset reset value, so power-up loads it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r  <= `EPC_PRESET_RST;
         dir_r  <= 1'b0;
         seen_r <= 1'b0;
         hit_r  <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         if (step)
            dir_r <= up;
         // A mark in the re-arm cycle still counts as seen
         if (ref_ev & (refmode == `EPC_REF_ONCE))
            seen_r <= 1'b1;
         else if (rearm_cmd)
            seen_r <= 1'b0;
         // Entering equality only, so a parked count fires once
         hit_r <= (cnt_nxt == cmp_r) & (cnt_r != cmp_r);
      end
   end

   // Exposure tracking; a new start while busy restarts the exposure
   // Odd lengths take the midpoint rounded down
   wire [EXP_W-1:0] half = exp_len_r >> 1;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exp_busy_r <= 1'b0;
         exp_cnt_r  <= {EXP_W{1'b0}};
         exp_len_r  <= {EXP_W{1'b0}};
         mid_r      <= `EPC_ZERO32;
         meas_r     <= `EPC_ZERO32;
         mvalid_r   <= 1'b0;
      end else begin
         mvalid_r <= 1'b0;
         if (exp_start) begin
            exp_busy_r <= 1'b1;
            exp_cnt_r  <= {EXP_W{1'b0}};
            exp_len_r  <= exp_len;
         end else if (exp_busy_r) begin
            if (exp_cnt_r == half)
               mid_r <= cnt_r;
            if (exp_cnt_r == exp_len_r) begin
               exp_busy_r <= 1'b0;
               meas_r     <= (exp_cnt_r == half) ? cnt_r : mid_r;
               mvalid_r   <= 1'b1;
            end else begin
               exp_cnt_r <= exp_cnt_r + {{(EXP_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   assign pos_count  = cnt_r;
   assign meas_pos   = meas_r;
   assign meas_valid = mvalid_r;
   assign pos_hit    = hit_r;
   assign trig_out   = trig_r;

endmodule // epc_top

// ### hdl/epc_defs.vh
// Register map, field layout, modes and reset values of the encoder counter.
// Assumes APB with 32-bit data and byte addresses on an 8-bit paddr.
`ifndef EPC_DEFS_VH
`define EPC_DEFS_VH

`define EPC_ADDR_W        8
`define EPC_ADDR_CTRL     8'h00
`define EPC_ADDR_MAP      8'h04
`define EPC_ADDR_MAXV     8'h08
`define EPC_ADDR_PRESET   8'h0c
`define EPC_ADDR_CMD      8'h10
`define EPC_ADDR_COUNT    8'h14
`define EPC_ADDR_STATUS   8'h18
`define EPC_ADDR_CAPT     8'h1c
`define EPC_ADDR_CMP      8'h20

`define EPC_CTRL_INTERP   1:0
`define EPC_CTRL_REFMODE  3:2
`define EPC_CTRL_W        4
`define EPC_CTRL_RST      4'h0

`define EPC_INT_X1        2'h0
`define EPC_INT_X2        2'h1
`define EPC_INT_X4        2'h2
`define EPC_REF_NONE      2'h0
`define EPC_REF_ONCE      2'h1
`define EPC_REF_ALL       2'h2
`define EPC_MODE_BAD      2'h3

`define EPC_MAP_IN0       1:0
`define EPC_MAP_IN1       3:2
`define EPC_MAP_IN2       5:4
`define EPC_MAP_W         6
`define EPC_MAP_RST       6'h24
`define EPC_FN_A          2'h0
`define EPC_FN_B          2'h1
`define EPC_FN_REF        2'h2
`define EPC_FN_TRIG       2'h3

`define EPC_CMD_LOAD      0
`define EPC_CMD_REARM     1
`define EPC_ST_SEEN       0
`define EPC_ST_DIR        1

`define EPC_MAXV_RST      32'hffffffff
`define EPC_PRESET_RST    32'h00000000
`define EPC_CMP_RST       32'h00000000
`define EPC_ZERO32        32'h00000000
`define EPC_ONE32         32'h00000001

`endif

// ### tb/epc_properties.sv
// Port checker for the encoder counter top.
// Assumes a bind into epc_top; EXP_W follows the design.
`timescale 1ns/10ps
`include "epc_defs.vh"
module epc_props #(
   parameter EXP_W = 24
) (
   input logic             pclk,
   input logic             presetn,
   input logic             psel,
   input logic             penable,
   input logic             pwrite,
   input logic [7:0]       paddr,
   input logic [31:0]      pwdata,
   input logic             pslverr,
   input logic [2:0]       mf_in,
   input logic             exp_start,
   input logic [EXP_W-1:0] exp_len,
   input logic [31:0]      pos_count,
   input logic [31:0]      meas_pos,
   input logic             meas_valid,
   input logic             pos_hit
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire map_wr = psel && !penable && pwrite && paddr == `EPC_ADDR_MAP;
   a_err_in_access: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access phase");
   a_map_dup: assert property (map_wr && pwdata[5:0] == 6'h00
      |=> pslverr) else $error("duplicate map accepted");
   a_map_reftrig: assert property (map_wr && pwdata[5:0] == 6'h38
      |=> pslverr) else $error("reference with trigger accepted");
   // Bus writes may load or nudge the count, so only quiet spans count
   a_count_quiet: assert property ((!psel && $stable(mf_in))[*4]
      |-> $stable(pos_count)) else $error("count moved while idle");
   a_valid_pulse: assert property (meas_valid |=> !meas_valid)
      else $error("meas_valid longer than one cycle");
   a_meas_hold: assert property (!meas_valid |-> $stable(meas_pos))
      else $error("meas_pos changed without result");
   a_start_quiet: assert property (exp_start |=> !meas_valid)
      else $error("result right after start");
   a_meas_time: assert property (exp_start && exp_len == 4
      ##1 !exp_start [*5] |=> meas_valid) else $error("result late");
   a_hit_pulse: assert property (pos_hit |=> !pos_hit)
      else $error("pos_hit longer than one cycle");
   c_meas: cover property (meas_valid);
   c_hit: cover property (pos_hit);
   c_err: cover property (pslverr);
endmodule // epc_props

bind epc_top epc_props #(.EXP_W(EXP_W)) i_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
   .mf_in(mf_in), .exp_start(exp_start), .exp_len(exp_len),
   .pos_count(pos_count), .meas_pos(meas_pos), .meas_valid(meas_valid),
   .pos_hit(pos_hit));

// ### tb/epc_enc_model.sv
// Behavioural quadrature encoder with reference track.
// Assumes pin 0 track A, pin 1 track B, pin 2 reference or trigger.
`timescale 1ns/10ps
module epc_enc_model (
   input  logic       pclk,
   output logic [2:0] mf_in
);
   logic [1:0] ph = 2'h0;
   initial mf_in = 3'h0;
   // Track A leads B when moving up; gap 0 is the fastest legal rate
   task automatic move(input bit up, input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         ph = up ? ph + 2'h1 : ph - 2'h1;
         @(posedge pclk);
         mf_in[1:0] <= {ph[1], ph[1] ^ ph[0]};
         repeat (gap) @(posedge pclk);
      end
      // Let the last level pass the synchroniser and reach the counter
      repeat (3) @(posedge pclk);
   endtask
   task automatic mark(input int n);
      @(posedge pclk);
      mf_in[2] <= 1'b1;
      repeat (n) @(posedge pclk);
      mf_in[2] <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
endmodule // epc_enc_model

// ### tb/epc_top_tb_top.sv
// Self-checking bench for the encoder counter over APB.
// Assumes epc_top, the encoder model and the bound checker.
`timescale 1ns/10ps
`include "epc_defs.vh"
module epc_top_tb_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic        exp_start;
   logic [7:0]  paddr;
   logic [7:0]  exp_len;
   logic [31:0] pwdata;
   logic [31:0] p;
   logic [33:0] e;
   logic [31:0] r;
   int          hits = 0;
   wire         pready;
   wire         pslverr;
   wire         meas_valid;
   wire         pos_hit;
   wire         trig_out;
   wire  [31:0] prdata;
   wire  [31:0] pos_count;
   wire  [31:0] meas_pos;
   wire  [2:0]  mf_in;
   int          fail_count = 0;
   int          compares = 0;
   logic [33:0] bus_q[$];
   logic [31:0] meas_q[$];

   epc_top #(.EXP_W(8)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .mf_in(mf_in),
      .exp_start(exp_start), .exp_len(exp_len), .pos_count(pos_count),
      .meas_pos(meas_pos), .meas_valid(meas_valid), .pos_hit(pos_hit),
      .trig_out(trig_out));
   epc_enc_model i_enc (.pclk(pclk), .mf_in(mf_in));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic check(input string n, input logic [31:0] x,
                        input logic [31:0] g);
      compares++;
      if (g !== x) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic apb(input bit w, input logic [7:0] a,
                      input logic [31:0] d, input bit err);
      bus_q.push_back({w, err, d});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic expose(input logic [7:0] n);
      exp_start <= 1'b1;
      exp_len <= n;
      @(posedge pclk);
      exp_start <= 1'b0;
   endtask
   task automatic print_verdict;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Oldest note first: bus answers and mid-exposure counts
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         e = bus_q.pop_front();
         check("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
         if (!e[33] && !e[32]) check("prdata", e[31:0], prdata);
      end
      if (meas_valid === 1'b1) check("meas_pos", meas_q.pop_front(), meas_pos);
      if (pos_hit === 1'b1) hits++;
   end

   initial begin
      #60000;
      fail_count++;
      $display("watchdog expired");
      print_verdict();
   end

   initial begin
      {psel, penable, pwrite, exp_start} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      exp_len = 8'h00;
      presetn = 1'b0;
      p = $urandom(31);
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, `EPC_ADDR_CTRL, 32'h0, 0);
      apb(0, `EPC_ADDR_MAP, 32'h24, 0);
      apb(0, `EPC_ADDR_MAXV, 32'hffffffff, 0);
      apb(0, `EPC_ADDR_COUNT, 32'h0, 0);
      i_enc.move(1, 16, 3);
      apb(0, `EPC_ADDR_COUNT, 32'h4, 0);
      apb(0, `EPC_ADDR_STATUS, 32'h2, 0);
      i_enc.move(0, 8, 3);
      apb(0, `EPC_ADDR_COUNT, 32'h2, 0);
      check("pos_count", 32'h2, pos_count);
      $display("test single done");
      p = $urandom % 990 + 10;
      apb(1, `EPC_ADDR_CTRL, 32'h1, 0);
      apb(1, `EPC_ADDR_PRESET, p, 0);
      apb(1, `EPC_ADDR_CMD, 32'h1, 0);
      apb(0, `EPC_ADDR_COUNT, p, 0);
      i_enc.move(0, 8, 0);
      apb(0, `EPC_ADDR_COUNT, p - 4, 0);
      $display("test double done");
      apb(1, `EPC_ADDR_CTRL, 32'h2, 0);
      apb(1, `EPC_ADDR_MAXV, 32'h5, 0);
      apb(1, `EPC_ADDR_PRESET, 32'h3, 0);
      apb(1, `EPC_ADDR_CMD, 32'h1, 0);
      apb(1, `EPC_ADDR_CMP, 32'h5, 0);
      hits = 0;
      i_enc.move(1, 4, 3);
      apb(0, `EPC_ADDR_COUNT, 32'h1, 0);
      i_enc.move(0, 2, 3);
      apb(0, `EPC_ADDR_COUNT, 32'h5, 0);
      check("pos_hit", 32'h2, hits);
      $display("test wrap done");
      // Preset stays below the maximum, as software must keep it
      p = $urandom % 90;
      apb(1, `EPC_ADDR_MAXV, 32'd100, 0);
      apb(1, `EPC_ADDR_PRESET, p, 0);
      apb(1, `EPC_ADDR_CMD, 32'h1, 0);
      i_enc.move(1, 4, 3);
      i_enc.mark(3);
      apb(0, `EPC_ADDR_COUNT, p + 4, 0);
      apb(1, `EPC_ADDR_CTRL, 32'h6, 0);
      i_enc.mark(3);
      apb(0, `EPC_ADDR_COUNT, p, 0);
      i_enc.move(1, 4, 3);
      i_enc.mark(3);
      apb(0, `EPC_ADDR_COUNT, p + 4, 0);
      apb(0, `EPC_ADDR_STATUS, 32'h3, 0);
      apb(1, `EPC_ADDR_CMD, 32'h2, 0);
      i_enc.mark(3);
      apb(0, `EPC_ADDR_COUNT, p, 0);
      apb(1, `EPC_ADDR_CTRL, 32'ha, 0);
      repeat (2) begin
         i_enc.move(1, 4, 3);
         i_enc.mark(3);
         apb(0, `EPC_ADDR_COUNT, p, 0);
      end
      $display("test reference done");
      apb(1, `EPC_ADDR_MAP, 32'h0, 1);
      apb(1, `EPC_ADDR_MAP, 32'h38, 1);
      apb(1, `EPC_ADDR_CTRL, 32'h3, 1);
      apb(1, `EPC_ADDR_MAXV, 32'h0, 1);
      r = $urandom;
      apb(0, {2'h1, r[5:0]}, 32'h0, 1);
      apb(0, `EPC_ADDR_MAP, 32'h24, 0);
      $display("test refusal done");
      meas_q.push_back(p);
      expose(8'd9);
      @(posedge pclk);
      expose(8'd4);
      repeat (12) @(posedge pclk);
      meas_q.push_back(p + 4);
      r = $urandom;
      expose({1'b1, r[6:0]});
      i_enc.move(1, 4, 3);
      repeat (120) @(posedge pclk);
      i_enc.move(1, 4, 3);
      repeat (120) @(posedge pclk);
      check("results left", 32'h0, meas_q.size());
      $display("test exposure done");
      apb(1, `EPC_ADDR_MAP, 32'h34, 0);
      fork
         i_enc.mark(10);
         begin
            repeat (6) @(posedge pclk);
            check("trig_out", 32'h1, {31'h0, trig_out});
         end
      join
      $display("test trigger done");
      print_verdict();
   end
endmodule // epc_top_tb_top
